/* File: pkg/poe_cfg.svh */
// Notes on behaviour
// [RQ1] Mode code 0000 takes a stop request on either edge of the fault input.
// [RQ2] Codes 0001-0011 sample at clock/8, /16, /128 and need agreeing consecutive samples.
// [RQ3] Codes 0100-0110 sample the same way at clock/1, /2 and /4.
// [RQ4] Software writes only mode codes 0000 to 0110; other codes are forbidden.
// [RQ5] Each fault input has its own 4-bit sample count field.
// [RQ6] A per-input polarity bit inverts the pin before edge or level detection.
// [RQ7] The software stop register is sixteen bits wide.
// [RQ8] Software stop bits halt pwm pairs 0-1, 2-3, channels 0-2, 4-6, 7, timer 9.
// [RQ9] Each pwm channel 2 to 7 has a pair float enable; channel 2 bit 2, channel 3 bit 3.
// [RQ10] Flags 0, 12 and 9 may each be added to timer 3/4 stop conditions.
// [RQ11] Flags 8, 12 and 9 may each be added to timer 0 stop conditions.
// [RQ12] Flags 10, 12 and 9 may each be added to pwm 0/1 stop conditions.
// [RQ13] A detected fault on an own input stops every controlled pin group.
// [RQ14] Sampling outcomes can raise an interrupt.
// [RQ15] The run counter restarts on a disagreeing sample; the flag holds until cleared.
// [RQ16] Sample count field 0 means 4, 1 means 8, any other value means 16.
`ifndef POE_CFG_SVH
`define POE_CFG_SVH

`define OFS_FAULT8_CTRL     8'h00
`define OFS_FAULT10_CTRL    8'h04
`define OFS_FAULT11_CTRL    8'h08
`define OFS_SW_STOP         8'h0C
`define OFS_PAIR_HIZ        8'h10
`define OFS_CH34_ADD        8'h14
`define OFS_CH0_ADD         8'h18
`define OFS_PWM01_ADD       8'h1C
`define OFS_STATUS          8'h20
`define OFS_MASK            8'h24
`define OFS_STOP_STATE      8'h28

`define POS_DETECT_SELECT   0
`define POS_SAMPLE_COUNT    4
`define POS_POLARITY_FLIP   8
`define CTRL_RESET          16'h0000
`define REG_RESET           16'h0000

`define CNT_SEL_FOUR        4'h0
`define CNT_SEL_EIGHT       4'h1
`define RUN_FOUR            5'h04
`define RUN_EIGHT           5'h08
`define RUN_SIXTEEN         5'h10

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: pkg/poe_pkg.sv */
package poe_pkg;

    // Detection mode, one value per legal code of the mode field.
    typedef enum logic [3:0] {
        MODE_EDGE,
        MODE_DIV8,
        MODE_DIV16,
        MODE_DIV128,
        MODE_DIV1,
        MODE_DIV2,
        MODE_DIV4
    } mode_t;

    // Stop group order of the stop_group output.
    typedef enum logic [2:0] {
        GRP_TIMER34,
        GRP_TIMER0,
        GRP_PWM01,
        GRP_PWM23,
        GRP_TIMER9,
        GRP_PWM02,
        GRP_PWM46,
        GRP_PWM7
    } group_t;

endpackage

/* File: rtl/port_output_stop_control.sv */
`timescale 1ns/1ps
`include "poe_cfg.svh"

module port_output_stop_control (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        fault_in_8_n,
    input  wire logic        fault_in_10_n,
    input  wire logic        fault_in_11_n,
    input  wire logic        fault0_detect_flag,
    input  wire logic        fault12_detect_flag,
    input  wire logic        fault9_detect_flag,
    output logic [7:0]       stop_group,
    output logic [5:0]       pair_hiz,
    output logic             irq
);

    // Tick of the sample clock chosen by a mode code.
    function automatic logic tick_of(input logic [3:0] mode, input logic [6:0] pre);
        poe_pkg::mode_t m;
        m = poe_pkg::mode_t'(mode);
        case (m)
            poe_pkg::MODE_DIV8:   tick_of = &pre[2:0];
            poe_pkg::MODE_DIV16:  tick_of = &pre[3:0];
            poe_pkg::MODE_DIV128: tick_of = &pre;
            poe_pkg::MODE_DIV1:   tick_of = 1'b1;
            poe_pkg::MODE_DIV2:   tick_of = pre[0];
            poe_pkg::MODE_DIV4:   tick_of = &pre[1:0];
            default:              tick_of = 1'b0;
        endcase
    endfunction

    // Consecutive agreeing samples that a count code asks for.
    function automatic logic [4:0] run_of(input logic [3:0] sel);
        if (sel == `CNT_SEL_FOUR) begin
            run_of = `RUN_FOUR;
        end else if (sel == `CNT_SEL_EIGHT) begin
            run_of = `RUN_EIGHT;
        end else begin
            run_of = `RUN_SIXTEEN;
        end
    endfunction

    // Byte-lane merge of a sixteen bit register with write data.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    logic [15:0] fault_ctrl [3];
    logic [15:0] sw_stop;
    logic [15:0] pair_float;
    logic [15:0] ch34_add;
    logic [15:0] ch0_add;
    logic [15:0] pwm01_add;
    logic [2:0]  flag;
    logic [2:0]  mask;
    logic [6:0]  prescale;
    logic [2:0]  prev_level;
    logic [4:0]  run [3];
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;

    wire  [2:0]  pins = {fault_in_11_n, fault_in_10_n, fault_in_8_n};
    logic [2:0]  level;
    logic [2:0]  tick;
    logic [2:0]  edge_seen;
    logic [2:0]  is_edge_mode;
    logic [2:0]  run_done;
    logic [2:0]  set_flag;

    // Per-input detection terms.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            // [RQ6] polarity flip
            level[i]        = pins[i] ^ fault_ctrl[i][`POS_POLARITY_FLIP];
            // [RQ2] [RQ3] sample clock select
            tick[i]         = tick_of(fault_ctrl[i][`POS_DETECT_SELECT +: 4], prescale);
            is_edge_mode[i] = fault_ctrl[i][`POS_DETECT_SELECT +: 4] ==
                              4'(poe_pkg::MODE_EDGE);
            // [RQ1] either edge
            edge_seen[i]    = level[i] != prev_level[i];
            // [RQ5] [RQ16] run length reached
            run_done[i]     = tick[i] && !level[i] &&
                              (run[i] + 5'h01 >= run_of(fault_ctrl[i][`POS_SAMPLE_COUNT +: 4]));
            set_flag[i]     = is_edge_mode[i] ? edge_seen[i] : run_done[i];
        end
    end

    // Bus decode terms.
    wire         do_write  = aw_got && w_got && !bvalid;
    wire         ar_take   = arvalid && arready;
    wire  [7:0]  wa        = aw_addr_q;
    wire         wr_ctrl8  = do_write && wa == `OFS_FAULT8_CTRL;
    wire         wr_ctrl10 = do_write && wa == `OFS_FAULT10_CTRL;
    wire         wr_ctrl11 = do_write && wa == `OFS_FAULT11_CTRL;
    wire         wr_sw     = do_write && wa == `OFS_SW_STOP;
    wire         wr_pair   = do_write && wa == `OFS_PAIR_HIZ;
    wire         wr_ch34   = do_write && wa == `OFS_CH34_ADD;
    wire         wr_ch0    = do_write && wa == `OFS_CH0_ADD;
    wire         wr_pwm01  = do_write && wa == `OFS_PWM01_ADD;
    wire         wr_status = do_write && wa == `OFS_STATUS;
    wire         wr_mask   = do_write && wa == `OFS_MASK;
    wire         wr_hit    = wr_ctrl8 | wr_ctrl10 | wr_ctrl11 | wr_sw | wr_pair | wr_ch34 |
                             wr_ch0 | wr_pwm01 | wr_status | wr_mask |
                             (wa == `OFS_STOP_STATE);
    wire  [2:0]  clr_flag  = wr_status && w_strb_q[0] ? w_data_q[2:0] : 3'h0;

    // Stop condition of each group.
    wire         any_fault = |flag;
    logic [7:0]  next_stop;
    always_comb begin
        // [RQ13] own faults stop all
        next_stop = {8{any_fault}};
        // [RQ10] timer 3/4 sources
        next_stop[poe_pkg::GRP_TIMER34] = any_fault |
            (ch34_add[0] & fault0_detect_flag) | (ch34_add[1] & fault12_detect_flag) |
            (ch34_add[2] & fault9_detect_flag);
        // [RQ11] timer 0 sources
        next_stop[poe_pkg::GRP_TIMER0] = any_fault |
            (ch0_add[0] & flag[0]) | (ch0_add[1] & fault12_detect_flag) |
            (ch0_add[2] & fault9_detect_flag);
        // [RQ12] pwm 0/1 sources
        next_stop[poe_pkg::GRP_PWM01] = any_fault | sw_stop[0] |
            (pwm01_add[0] & flag[1]) | (pwm01_add[1] & fault12_detect_flag) |
            (pwm01_add[2] & fault9_detect_flag);
        // [RQ8] software stop bits
        next_stop[poe_pkg::GRP_PWM23] = any_fault | sw_stop[1];
        next_stop[poe_pkg::GRP_TIMER9] = any_fault | sw_stop[2];
        next_stop[poe_pkg::GRP_PWM02] = any_fault | sw_stop[3];
        next_stop[poe_pkg::GRP_PWM46] = any_fault | sw_stop[4];
        next_stop[poe_pkg::GRP_PWM7] = any_fault | sw_stop[5];
    end

    // [RQ9] pair float per channel
    wire  [5:0]  next_pair_hiz = pair_float[7:2] & {
        next_stop[poe_pkg::GRP_PWM7],
        {3{next_stop[poe_pkg::GRP_PWM46]}},
        next_stop[poe_pkg::GRP_PWM23],
        next_stop[poe_pkg::GRP_PWM23] | next_stop[poe_pkg::GRP_PWM02]};

    // Read data selection.
    logic [15:0] rd_val;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            `OFS_FAULT8_CTRL:  rd_val = fault_ctrl[0];
            `OFS_FAULT10_CTRL: rd_val = fault_ctrl[1];
            `OFS_FAULT11_CTRL: rd_val = fault_ctrl[2];
            `OFS_SW_STOP:      rd_val = sw_stop;
            `OFS_PAIR_HIZ:     rd_val = pair_float;
            `OFS_CH34_ADD:     rd_val = ch34_add;
            `OFS_CH0_ADD:      rd_val = ch0_add;
            `OFS_PWM01_ADD:    rd_val = pwm01_add;
            `OFS_STATUS:       rd_val = {13'h0000, flag};
            `OFS_MASK:         rd_val = {13'h0000, mask};
            `OFS_STOP_STATE:   rd_val = {2'h0, pair_hiz, stop_group};
            default: begin
                rd_val = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Prescaler for the divided sample clocks.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= 7'h00;
        end else begin
            prescale <= prescale + 7'h01;
        end
    end

    // Run counters, previous levels and sticky flags.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_level <= 3'h7;
            flag       <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                run[i] <= 5'h00;
            end
        end else begin
            prev_level <= level;
            // [RQ15] set wins over clear
            flag       <= (flag & ~clr_flag) | set_flag;
            for (int i = 0; i < 3; i++) begin
                // [RQ15] restart on disagreement
                if (is_edge_mode[i] || (tick[i] && level[i])) begin
                    run[i] <= 5'h00;
                end else if (tick[i] && run[i] != `RUN_SIXTEEN) begin
                    run[i] <= run[i] + 5'h01;
                end
            end
        end
    end

    // Configuration registers written over the bus.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_ctrl[0] <= `CTRL_RESET;
            fault_ctrl[1] <= `CTRL_RESET;
            fault_ctrl[2] <= `CTRL_RESET;
            sw_stop       <= `REG_RESET;
            pair_float    <= `REG_RESET;
            ch34_add      <= `REG_RESET;
            ch0_add       <= `REG_RESET;
            pwm01_add     <= `REG_RESET;
            mask          <= 3'h0;
        end else begin
            // [RQ4] only legal codes expected
            if (wr_ctrl8)  fault_ctrl[0] <= merge(fault_ctrl[0], w_data_q, w_strb_q);
            if (wr_ctrl10) fault_ctrl[1] <= merge(fault_ctrl[1], w_data_q, w_strb_q);
            if (wr_ctrl11) fault_ctrl[2] <= merge(fault_ctrl[2], w_data_q, w_strb_q);
            // [RQ7] sixteen bit stop register
            if (wr_sw)     sw_stop <= merge(sw_stop, w_data_q, w_strb_q);
            if (wr_pair)   pair_float <= merge(pair_float, w_data_q, w_strb_q);
            if (wr_ch34)   ch34_add <= merge(ch34_add, w_data_q, w_strb_q);
            if (wr_ch0)    ch0_add <= merge(ch0_add, w_data_q, w_strb_q);
            if (wr_pwm01)  pwm01_add <= merge(pwm01_add, w_data_q, w_strb_q);
            if (wr_mask && w_strb_q[0]) mask <= w_data_q[2:0];
        end
    end

    // Registered outputs toward the pins and the interrupt controller.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_group <= 8'h00;
            pair_hiz   <= 6'h00;
            irq        <= 1'b0;
        end else begin
            stop_group <= next_stop;
            pair_hiz   <= next_pair_hiz;
            // [RQ14] unmasked flags interrupt
            irq        <= |(flag & mask);
        end
    end

    // Write address and data capture, in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got    <= 1'b1;
                awready   <= 1'b0;
                aw_addr_q <= awaddr;
            end else if (do_write) begin
                aw_got    <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got    <= 1'b1;
                wready   <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end else if (do_write) begin
                w_got    <= 1'b0;
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Write response after both halves are in.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel: one read at a time, data a cycle after the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else if (ar_take) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {16'h0000, rd_val};
            rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

endmodule

/* File: testbench/poe_stop_monitor.sv */
`timescale 1ns/1ps
module poe_stop_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [7:0]  stop_group,
    input wire logic [5:0]  pair_hiz,
    input wire logic        irq
);
    // All checks share the bus clock and stay quiet while reset is held.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Answer timing and release of the register bus.
    a_rd_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer missing");
    a_rd_release: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer not released");
    a_wr_release: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer not released");
    a_wr_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_rd_unmapped: assert property (
        arvalid && arready && araddr > 8'h28 |=> rresp == 2'h2 && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    // A floated channel among 4 to 6 always sits inside the stopped pwm 4-6 group.
    a_pair_mid: assert property (|pair_hiz[4:2] |-> stop_group[6])
        else $error("pair floated without group stop");
    a_reset_quiet: assert property ($rose(aresetn) |-> stop_group == 8'h00 && !irq)
        else $error("outputs active after reset");
endmodule

bind port_output_stop_control poe_stop_monitor u_mon (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .stop_group, .pair_hiz, .irq
);

/* File: testbench/fault_pin_model.sv */
`timescale 1ns/1ps
module fault_pin_model (
    input  wire logic [2:0] pin_lvl,
    input  wire logic [2:0] ext_req,
    input  wire logic       aclk,
    output logic      [2:0] pin_n,
    output logic      [2:0] ext_flag
);
    // Pins idle high and external flags idle low before the first edge.
    initial begin
        pin_n = 3'b111;
        ext_flag = 3'b000;
    end

    // Fault sources change only just after a rising edge, like clocked logic.
    always @(posedge aclk) begin
        pin_n <= pin_lvl;
        ext_flag <= ext_req;
    end
endmodule

/* File: testbench/port_output_stop_control_tb_top.sv */
`timescale 1ns/1ps
`include "poe_cfg.svh"
module port_output_stop_control_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [2:0]  lvl = 3'b111;
    logic [2:0]  ext = 3'b000;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  stop_group;
    logic [5:0]  pair_hiz;
    logic [2:0]  pin_n, flag;
    logic [33:0] q[$];
    logic [5:0]  hz [6] = '{6'h00, 6'h03, 6'h00, 6'h01, 6'h1C, 6'h20};
    logic [7:0]  cs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h14, 8'h24, 8'hF4};
    int          per [9] = '{8, 16, 128, 1, 2, 4, 1, 1, 1};
    int          nn [9] = '{4, 4, 4, 4, 4, 4, 8, 16, 16};
    int          err_count = 0;
    int          n_tests = 0;
    int          seed = 32'hd6f2;

    // Free running clock, half period 10 ns.
    always #10 aclk = ~aclk;

    port_output_stop_control dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'b0011), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .fault_in_8_n(pin_n[0]), .fault_in_10_n(pin_n[1]),
        .fault_in_11_n(pin_n[2]), .fault0_detect_flag(flag[0]),
        .fault12_detect_flag(flag[1]), .fault9_detect_flag(flag[2]),
        .stop_group, .pair_hiz, .irq
    );

    fault_pin_model far (.pin_lvl(lvl), .ext_req(ext), .aclk, .pin_n, .ext_flag(flag));

    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic ok(input int w);
        case (w)
            0: ok = awready && wready;
            1: ok = bvalid;
            2: ok = arready;
            default: ok = rvalid;
        endcase
    endfunction

    // Waits for one handshake under a bound; running out ends the run.
    task automatic hs(input int w);
        int k;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (!ok(w) && k < 200);
        if (!ok(w)) begin
            err_count++;
            finish_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
        q.push_back({r, 32'h0000_0000});
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hs(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        hs(1);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hs(2);
        arvalid <= 1'b0;
        hs(3);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic low(input int n, input int p);
        lvl[2] <= 1'b0;
        repeat (n * p) @(posedge aclk);
        lvl[2] <= 1'b1;
    endtask

    // Takes the oldest expectation whenever the block answers on the bus.
    always @(posedge aclk) begin
        if (rvalid && rready)
            chk("read", {rresp, rdata}, q.pop_front());
        else if (bvalid && bready)
            chk("write", {bresp, 32'h0000_0000}, q.pop_front());
    end

    initial begin
        logic [31:0] v;
        int i;
        int b;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i <= 10; i++)
            rd(8'(4 * i), 34'(0));
        rd(8'h2C, {`RESP_SLVERR, 32'h0000_0000});
        wr(8'h2C, 16'hFFFF, `RESP_SLVERR);
        $display("test reset done");
        for (i = 0; i < 3; i++) begin
            v = $random(seed);
            v[3:0] = v[3:0] % 4'h7;
            wr(8'(4 * i), v[15:0] & 16'h01FF);
            rd(8'(4 * i), 34'(v[15:0] & 16'h01FF));
            wr(8'(4 * i), 16'h0000);
        end
        repeat (4) @(posedge aclk);
        wr(`OFS_STATUS, 16'h0007);
        rd(`OFS_STATUS, 34'(0));
        $display("test setup done");
        wr(`OFS_PAIR_HIZ, 16'h00FC);
        for (i = 0; i < 6; i++) begin
            wr(`OFS_SW_STOP, 16'(1 << i));
            rd(`OFS_STOP_STATE, 34'({hz[i], 8'(1 << (i + 2))}));
        end
        wr(`OFS_SW_STOP, 16'h0000);
        $display("test software stop done");
        for (i = 0; i < 3; i++)
            for (b = 0; b < 3; b++)
                if (i == 0 || b > 0) begin
                    ext <= 3'(1 << b);
                    repeat (3) @(posedge aclk);
                    rd(`OFS_STOP_STATE, 34'(0));
                    wr(8'(`OFS_CH34_ADD + 4 * i), 16'(1 << b));
                    rd(`OFS_STOP_STATE, 34'(1 << i));
                    wr(8'(`OFS_CH34_ADD + 4 * i), 16'h0000);
                end
        ext <= 3'b000;
        $display("test flag routing done");
        lvl[0] <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(`OFS_STATUS, 34'(1));
        rd(`OFS_STOP_STATE, 34'(16'h3FFF));
        chk("irq", irq, 0);
        wr(`OFS_MASK, 16'h0001);
        chk("irq", irq, 1);
        wr(`OFS_STATUS, 16'h0001);
        rd(`OFS_STATUS, 34'(0));
        lvl[0] <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(`OFS_STATUS, 34'(1));
        wr(`OFS_STATUS, 16'h0001);
        wr(`OFS_MASK, 16'h0004);
        chk("irq", irq, 0);
        wr(`OFS_FAULT10_CTRL, 16'h0104);
        repeat (8) @(posedge aclk);
        rd(`OFS_STATUS, 34'(2));
        wr(`OFS_FAULT10_CTRL, 16'h0004);
        wr(`OFS_STATUS, 16'h0002);
        repeat (8) @(posedge aclk);
        rd(`OFS_STATUS, 34'(0));
        $display("test edge and polarity done");
        for (i = 0; i < 9; i++) begin
            wr(`OFS_FAULT11_CTRL, {8'h00, cs[i]});
            // One high sample at the new rate clears a run left by the last mode.
            repeat (per[i]) @(posedge aclk);
            low(nn[i] - 1, per[i]);
            repeat (per[i]) @(posedge aclk);
            low(nn[i] - 1, per[i]);
            repeat (4) @(posedge aclk);
            rd(`OFS_STATUS, 34'(0));
            low(nn[i] + 1, per[i]);
            repeat (4) @(posedge aclk);
            rd(`OFS_STATUS, 34'(4));
            chk("irq", irq, 1);
            wr(`OFS_STATUS, 16'h0004);
        end
        $display("test sampled modes done");
        finish_test();
    end
endmodule
